// ===== rtl/fpg_consts.vh
`ifndef FPG_CONSTS_VH
`define FPG_CONSTS_VH

// ****************************************
// Register addresses: bit 8 selects the expanded bank
// ****************************************
`define FPG_ADDR_W          9
`define FPG_ADDR_TWO_DATA   9'h002
`define FPG_ADDR_FOUR_DATA  9'h004
`define FPG_ADDR_FIVE_DATA  9'h005
`define FPG_ADDR_SIX_DATA   9'h006
`define FPG_ADDR_TWO_DIR    9'h0f6
`define FPG_ADDR_TWO_STYLE  9'h0f7
`define FPG_ADDR_UPPER_CFG  9'h100
`define FPG_ADDR_FOUR_DIR   9'h102
`define FPG_ADDR_FIVE_DIR   9'h104
`define FPG_ADDR_SIX_DIR    9'h106

// ****************************************
// Reset and fixed read values
// ****************************************
`define FPG_DIR_RESET       8'hff
`define FPG_DATA_RESET      8'h00
`define FPG_ALL_ONES        8'hff
`define FPG_UNMAPPED_READ   8'h00
`define FPG_CFG_RESET       5'h00
`define FPG_STYLE_RESET     1'b1
`define FPG_UPPER_RESET     3'h7
`define FPG_CFG_READ_ONES   3'h7

// ****************************************
// Field positions and special pins
// ****************************************
`define FPG_STYLE_BIT       0
`define FPG_CFG_FOUR_BIT    0
`define FPG_CFG_FIVE_BIT    1
`define FPG_CFG_SIX_BIT     2
`define FPG_CFG_KEEP_LSB    3
`define FPG_CC_MASK         8'h08
`define FPG_CMP_MASK        8'h0c
`define FPG_NO_MASK         8'h00

`endif

// ===== rtl/fpg_port.v
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// One 8-bit port: pin drive and read-back
// ****************************************
module fpg_port (
    input  wire       ref_clk,
    input  wire       rst,
    input  wire [7:0] dir,
    input  wire [7:0] latch,
    input  wire       push_pull,
    input  wire [7:0] force_in_mask,
    input  wire [7:0] cc_mask,
    input  wire [7:0] pin_in,
    output wire [7:0] pin_out,
    output wire [7:0] pin_oe_n,
    output wire [7:0] rd_value
);

    reg [7:0] sync1_ff;
    reg [7:0] sync2_ff;

    always @(posedge ref_clk) begin
        if (rst) begin
            sync1_ff <= 8'h00;
            sync2_ff <= 8'h00;
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_bit
            wire is_out;
            wire open_drain;
            // Comparator inputs never drive
            assign is_out = ~dir[i] & ~force_in_mask[i];
            // Current pad floats or sinks, never pushes high
            assign open_drain = ~push_pull | cc_mask[i];
            assign pin_oe_n[i] = ~(is_out & (~open_drain | ~latch[i]));
            assign pin_out[i]  = latch[i];
            // Inputs show the synchronised pin, outputs and the current pad show the latch
            assign rd_value[i] = (is_out | cc_mask[i]) ? latch[i] : sync2_ff[i];
        end
    endgenerate

endmodule

`default_nettype wire

// ===== rtl/fpg_top.v

`timescale 1ns/10ps
`default_nettype none
`include "fpg_consts.vh"

// ****************************************
// Register file and four port slices
// ****************************************
module fpg_top (
    input  wire                     ref_clk,
    input  wire                     rst,
    input  wire [`FPG_ADDR_W-1:0]   reg_addr,
    input  wire [7:0]               reg_wdata,
    input  wire                     reg_wr,
    input  wire                     reg_rd,
    output wire [7:0]               reg_rdata,
    input  wire [7:0]               two_pin_in,
    output wire [7:0]               two_pin_out,
    output wire [7:0]               two_pin_oe_n,
    input  wire [7:0]               four_pin_in,
    output wire [7:0]               four_pin_out,
    output wire [7:0]               four_pin_oe_n,
    input  wire [7:0]               five_pin_in,
    output wire [7:0]               five_pin_out,
    output wire [7:0]               five_pin_oe_n,
    input  wire [7:0]               six_pin_in,
    output wire [7:0]               six_pin_out,
    output wire [7:0]               six_pin_oe_n
);

    // ****************************************
    // Registers
    // ****************************************
    reg [7:0] port_two_data_ff;
    reg [7:0] port_four_data_ff;
    reg [7:0] port_five_data_ff;
    reg [7:0] port_six_data_ff;
    reg [7:0] port_two_direction_ff;
    reg [7:0] port_four_direction_ff;
    reg [7:0] port_five_direction_ff;
    reg [7:0] port_six_direction_ff;
    reg       port_two_drive_style_ff;
    reg [2:0] upper_ports_drive_config_ff;
    reg [4:0] upper_cfg_keep_ff;
    reg [7:0] rdata_ff;
    reg [7:0] nxt_rdata;

    wire [7:0] two_rd;
    wire [7:0] four_rd;
    wire [7:0] five_rd;
    wire [7:0] six_rd;

    // ****************************************
    // Register writes
    // ****************************************
    // Data latches are cleared so that no pin starts unknown
    always @(posedge ref_clk) begin
        if (rst) begin
            port_two_data_ff            <= `FPG_DATA_RESET;
            port_four_data_ff           <= `FPG_DATA_RESET;
            port_five_data_ff           <= `FPG_DATA_RESET;
            port_six_data_ff            <= `FPG_DATA_RESET;
            port_two_direction_ff       <= `FPG_DIR_RESET;
            port_four_direction_ff      <= `FPG_DIR_RESET;
            port_five_direction_ff      <= `FPG_DIR_RESET;
            port_six_direction_ff       <= `FPG_DIR_RESET;
            port_two_drive_style_ff     <= `FPG_STYLE_RESET;
            upper_ports_drive_config_ff <= `FPG_UPPER_RESET;
            upper_cfg_keep_ff           <= `FPG_CFG_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `FPG_ADDR_TWO_DATA) begin
                port_two_data_ff <= reg_wdata;
            end else if (reg_addr == `FPG_ADDR_FOUR_DATA) begin
                port_four_data_ff <= reg_wdata;
            end else if (reg_addr == `FPG_ADDR_FIVE_DATA) begin
                port_five_data_ff <= reg_wdata;
            end else if (reg_addr == `FPG_ADDR_SIX_DATA) begin
                port_six_data_ff <= reg_wdata;
            end else if (reg_addr == `FPG_ADDR_TWO_DIR) begin
                port_two_direction_ff <= reg_wdata;
            end else if (reg_addr == `FPG_ADDR_TWO_STYLE) begin
                port_two_drive_style_ff <= reg_wdata[`FPG_STYLE_BIT];
            end else if (reg_addr == `FPG_ADDR_UPPER_CFG) begin
                upper_ports_drive_config_ff <= reg_wdata[2:0];
                // Spare upper bits are only stored for read-back
                upper_cfg_keep_ff <= reg_wdata[7:`FPG_CFG_KEEP_LSB];
            end else if (reg_addr == `FPG_ADDR_FOUR_DIR) begin
                port_four_direction_ff <= reg_wdata;
            end else if (reg_addr == `FPG_ADDR_FIVE_DIR) begin
                port_five_direction_ff <= reg_wdata;
            end else if (reg_addr == `FPG_ADDR_SIX_DIR) begin
                port_six_direction_ff <= reg_wdata;
            end
        end
    end

    // ****************************************
    // Read path, answered one cycle after the strobe
    // ****************************************
    // A write taken at the same edge is not yet visible here
    always @* begin
        nxt_rdata = rdata_ff;
        if (reg_rd) begin
            if (reg_addr == `FPG_ADDR_TWO_DATA) begin
                nxt_rdata = two_rd;
            end else if (reg_addr == `FPG_ADDR_FOUR_DATA) begin
                nxt_rdata = four_rd;
            end else if (reg_addr == `FPG_ADDR_FIVE_DATA) begin
                nxt_rdata = five_rd;
            end else if (reg_addr == `FPG_ADDR_SIX_DATA) begin
                nxt_rdata = six_rd;
            end else if (reg_addr == `FPG_ADDR_TWO_DIR) begin
                nxt_rdata = `FPG_ALL_ONES;
            end else if (reg_addr == `FPG_ADDR_TWO_STYLE) begin
                nxt_rdata = `FPG_ALL_ONES;
            end else if (reg_addr == `FPG_ADDR_UPPER_CFG) begin
                nxt_rdata = {upper_cfg_keep_ff, `FPG_CFG_READ_ONES};
            end else if (reg_addr == `FPG_ADDR_FOUR_DIR) begin
                nxt_rdata = port_four_direction_ff;
            end else if (reg_addr == `FPG_ADDR_FIVE_DIR) begin
                nxt_rdata = port_five_direction_ff;
            end else if (reg_addr == `FPG_ADDR_SIX_DIR) begin
                nxt_rdata = port_six_direction_ff;
            end else begin
                nxt_rdata = `FPG_UNMAPPED_READ;
            end
        end
    end

    // Read data holds until the next read strobe
    always @(posedge ref_clk) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    // ****************************************
    // Port slices
    // ****************************************
    // Port two takes its drive style from its own register
    fpg_port u_two (
        .ref_clk       (ref_clk),
        .rst           (rst),
        .dir           (port_two_direction_ff),
        .latch         (port_two_data_ff),
        .push_pull     (port_two_drive_style_ff),
        .force_in_mask (`FPG_NO_MASK),
        .cc_mask       (`FPG_NO_MASK),
        .pin_in        (two_pin_in),
        .pin_out       (two_pin_out),
        .pin_oe_n      (two_pin_oe_n),
        .rd_value      (two_rd)
    );

    // Bit 3 is the current pad: it sinks or floats, never pushes high
    fpg_port u_four (
        .ref_clk       (ref_clk),
        .rst           (rst),
        .dir           (port_four_direction_ff),
        .latch         (port_four_data_ff),
        .push_pull     (upper_ports_drive_config_ff[`FPG_CFG_FOUR_BIT]),
        .force_in_mask (`FPG_NO_MASK),
        .cc_mask       (`FPG_CC_MASK),
        .pin_in        (four_pin_in),
        .pin_out       (four_pin_out),
        .pin_oe_n      (four_pin_oe_n),
        .rd_value      (four_rd)
    );

    // Comparator lines at bits 2 and 3 never drive
    fpg_port u_five (
        .ref_clk       (ref_clk),
        .rst           (rst),
        .dir           (port_five_direction_ff),
        .latch         (port_five_data_ff),
        .push_pull     (upper_ports_drive_config_ff[`FPG_CFG_FIVE_BIT]),
        .force_in_mask (`FPG_CMP_MASK),
        .cc_mask       (`FPG_NO_MASK),
        .pin_in        (five_pin_in),
        .pin_out       (five_pin_out),
        .pin_oe_n      (five_pin_oe_n),
        .rd_value      (five_rd)
    );

    fpg_port u_six (
        .ref_clk       (ref_clk),
        .rst           (rst),
        .dir           (port_six_direction_ff),
        .latch         (port_six_data_ff),
        .push_pull     (upper_ports_drive_config_ff[`FPG_CFG_SIX_BIT]),
        .force_in_mask (`FPG_NO_MASK),
        .cc_mask       (`FPG_NO_MASK),
        .pin_in        (six_pin_in),
        .pin_out       (six_pin_out),
        .pin_oe_n      (six_pin_oe_n),
        .rd_value      (six_rd)
    );

endmodule

`default_nettype wire

// ===== testbench/fpg_pad.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Board side of one port
// ****************************************
module fpg_pad (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] board,
    output logic      [7:0] pin_level
);
    // Board logic sets every line that the device leaves floating
    assign pin_level = (pin_out & ~pin_oe_n) | (board & pin_oe_n);
endmodule

`default_nettype wire

// ===== testbench/fpg_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Port and register checker
// ****************************************
module fpg_top_asserts (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] two_pin_in,
    input wire logic [7:0] two_pin_oe_n,
    input wire logic [7:0] four_pin_out,
    input wire logic [7:0] four_pin_oe_n,
    input wire logic [7:0] five_pin_oe_n,
    input wire logic [7:0] six_pin_out,
    input wire logic [7:0] six_pin_oe_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_reset_all_inputs: assert property ($fell(rst) |->
        (two_pin_oe_n & four_pin_oe_n & five_pin_oe_n & six_pin_oe_n) == 8'hff) else $error("lines driven after reset");
    a_two_dir_ones: assert property (reg_rd && reg_addr == 9'h0f6 |=> reg_rdata == 8'hff)
        else $error("port two direction read not all ones");
    a_cfg_reads_ones: assert property (reg_rd && reg_addr == 9'h100 |=> reg_rdata[2:0] == 3'h7)
        else $error("drive config bits not read as one");
    a_cmp_stay_input: assert property (five_pin_oe_n[3:2] == 2'b11)
        else $error("comparator line driven");
    a_cc_never_high: assert property (!four_pin_oe_n[3] |-> !four_pin_out[3])
        else $error("current pad driven high");
    a_cc_read_latch: assert property (reg_rd && reg_addr == 9'h004 |=> reg_rdata[3] == $past(four_pin_out[3]))
        else $error("current pad read not latch");
    a_out_reads_latch: assert property (reg_rd && reg_addr == 9'h006 |=>
        ((reg_rdata ^ $past(six_pin_out)) & ~$past(six_pin_oe_n)) == 8'h00) else $error("output read not latch");
    a_in_reads_pin: assert property (reg_rd && reg_addr == 9'h002 && two_pin_oe_n == 8'hff
        && !$past(rst, 1) && !$past(rst, 2) |=> reg_rdata == $past(two_pin_in, 3)) else $error("input read not pin");
    a_four_dir_input: assert property (reg_wr && reg_addr == 9'h102 |=> (~four_pin_oe_n & $past(reg_wdata)) == 8'h00)
        else $error("port four input line driven");
    a_six_dir_input: assert property (reg_wr && reg_addr == 9'h106 |=> (~six_pin_oe_n & $past(reg_wdata)) == 8'h00)
        else $error("port six input line driven");
endmodule

bind fpg_top fpg_top_asserts i_fpg_top_asserts (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .two_pin_in, .two_pin_oe_n, .four_pin_out, .four_pin_oe_n, .five_pin_oe_n, .six_pin_out, .six_pin_oe_n);

`default_nettype wire

// ===== testbench/test_fpg_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "fpg_consts.vh"

module test_fpg_top;
    logic       ref_clk = 1'b0;
    logic       rst = 1'b1;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    wire  [7:0] reg_rdata;
    logic [7:0] brd [0:3] = '{8'h00, 8'h00, 8'h00, 8'h00};
    wire  [7:0] lvl [0:3];
    wire  [7:0] pout [0:3];
    wire  [7:0] poe [0:3];
    logic [7:0] dir [0:3] = '{8'hff, 8'hff, 8'hff, 8'hff};
    logic [7:0] dat [0:3];
    logic [3:0] pp = 4'hf;
    int         err_total = 0;
    int         samples_checked = 0;
    logic [8:0] dadr [0:3] = '{`FPG_ADDR_TWO_DATA, `FPG_ADDR_FOUR_DATA, `FPG_ADDR_FIVE_DATA, `FPG_ADDR_SIX_DATA};
    logic [8:0] madr [0:3] = '{`FPG_ADDR_TWO_DIR, `FPG_ADDR_FOUR_DIR, `FPG_ADDR_FIVE_DIR, `FPG_ADDR_SIX_DIR};

    always #50 ref_clk = ~ref_clk;

    fpg_top i_fpg_top (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .two_pin_in(lvl[0]), .two_pin_out(pout[0]), .two_pin_oe_n(poe[0]),
        .four_pin_in(lvl[1]), .four_pin_out(pout[1]), .four_pin_oe_n(poe[1]),
        .five_pin_in(lvl[2]), .five_pin_out(pout[2]), .five_pin_oe_n(poe[2]),
        .six_pin_in(lvl[3]), .six_pin_out(pout[3]), .six_pin_oe_n(poe[3]));

    for (genvar g = 0; g < 4; g++) begin : g_pad
        fpg_pad i_fpg_pad (.pin_out(pout[g]), .pin_oe_n(poe[g]), .board(brd[g]), .pin_level(lvl[g]));
    end

    // Lines that read the pin rather than the latch
    function automatic logic [7:0] inl(int p);
        return p == 2 ? dir[p] | `FPG_CMP_MASK : (p == 1 ? dir[p] & ~`FPG_CC_MASK : dir[p]);
    endfunction

    function automatic logic [7:0] oex(int p);
        return (p == 2 ? dir[p] | `FPG_CMP_MASK : dir[p]) | (pp[p] ? (p == 1 ? dat[p] & `FPG_CC_MASK : 8'h00) : dat[p]);
    endfunction

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [8:0] a, input logic [7:0] e, input string n);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(n, e, reg_rdata);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #2000000;
        err_total++;
        complete_run();
    end

    initial begin
        int         p;
        logic [7:0] c;
        void'($urandom(32'h055f9b92));
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        for (p = 0; p < 4; p++) begin
            rd(madr[p], 8'hff, "dir_reset");
            chk("oe_reset", 8'hff, poe[p]);
            dat[p] = 8'($urandom);
            wr(dadr[p], dat[p]);
        end
        rd(`FPG_ADDR_TWO_STYLE, 8'hff, "style");
        rd(`FPG_ADDR_UPPER_CFG, 8'h07, "cfg_reset");
        rd(9'h0ff, `FPG_UNMAPPED_READ, "unmapped");
        @(posedge ref_clk);
        brd[0] <= 8'ha5;
        repeat (3) @(posedge ref_clk);
        rd(dadr[0], 8'ha5, "pin_in");
        $display("reset test done");
        for (int i = 0; i < 250; i++) begin
            p = $urandom_range(3);
            case ($urandom_range(3))
                0: begin
                    dir[p] = i < 8 ? 8'h00 : 8'($urandom);
                    wr(madr[p], dir[p]);
                end
                1: begin
                    dat[p] = 8'($urandom);
                    wr(dadr[p], dat[p]);
                end
                2: begin
                    pp = 4'($urandom);
                    c = 8'($urandom);
                    wr(`FPG_ADDR_TWO_STYLE, {7'h00, pp[0]});
                    wr(`FPG_ADDR_UPPER_CFG, {c[7:3], pp[3:1]});
                    rd(`FPG_ADDR_UPPER_CFG, {c[7:3], 3'h7}, "cfg");
                end
                default: begin
                    @(posedge ref_clk);
                    brd[p] <= 8'($urandom);
                end
            endcase
            repeat (3) @(posedge ref_clk);
            rd(dadr[p], (inl(p) & brd[p]) | (~inl(p) & dat[p]), "data");
            rd(madr[p], p == 0 ? 8'hff : dir[p], "dir");
            chk("oe_n", oex(p), poe[p]);
            chk("pin_out", dat[p] & ~oex(p), pout[p] & ~oex(p));
        end
        $display("random test done");
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        pp = 4'hf;
        for (p = 0; p < 4; p++) begin
            dir[p] = 8'hff;
            rd(madr[p], 8'hff, "dir_rerun");
            chk("oe_rerun", 8'hff, poe[p]);
        end
        rd(`FPG_ADDR_UPPER_CFG, 8'h07, "cfg_rerun");
        rd(dadr[0], brd[0], "pin_rerun");
        $display("reset rerun test done");
        complete_run();
    end
endmodule

`default_nettype wire
